// [dsm_duty_speed_map.sv]
// Duty cycle to speed target map with Wishbone registers
//
// Register access over Wishbone and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
//
// Function
// - Maximum-speed code maps through fixed monotonic table, 300 to 36000 rpm.
// - Duty codes mean code/255 of full duty, zero to full.
// - Target interpolates linearly between minimum and maximum duty/speed points.
// - Over-range select 0 above maximum duty: target held at maximum speed.
// - Over-range select 1 above maximum duty: regulation bypassed, full output duty.
// - Minimum-speed code maps through own table: 0, 300 up to 10400 rpm.
// - Profile registers at indices 0x0100 to 0x0103, select bit 2 at 0x0109.
// - Host drives 25 Hz to 100 kHz; output PWM fixed at 48 kHz.
module dsm_duty_speed_map
   import dsm_pkg::*;
#(
   parameter int MEAS_TIMEOUT = MEAS_TIMEOUT_CYC, // cycles without edge = steady level
   parameter int OUT_PERIOD = OUT_PER_CYC // output PWM period in cycles
) (
   input wire logic clk, // system clock, 250 MHz
   input wire logic rst, // async reset, active high
   input wire logic wb_cyc_i, // Wishbone cycle
   input wire logic wb_stb_i, // Wishbone strobe
   input wire logic wb_we_i, // Wishbone write enable
   input wire logic [15:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte selects
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o, // Wishbone read data
   output logic wb_ack_o, // Wishbone acknowledge
   input wire logic pwm_cmd_in, // speed command PWM pin
   input wire logic [7:0] loop_duty, // regulator output duty, 0..255
   output logic [RPM_W-1:0] target_rpm, // target speed for regulator
   output logic regulation_bypass, // high when output forced to full duty
   output logic pwm_out // motor drive PWM, 48 kHz
);
   localparam int OCW = $clog2(OUT_PERIOD);

   // Register file state
   dsm_prof_t prof_q;
   dsm_prof_t prof_d;
   logic ack_q;
   logic ack_d;
   logic [31:0] dat_q;
   logic [31:0] dat_d;
   logic [13:0] idx;
   logic req;

   // Measurement state
   logic [2:0] sync_q;
   logic [2:0] sync_d;
   logic [MEAS_W-1:0] cnt_q;
   logic [MEAS_W-1:0] cnt_d;
   logic [MEAS_W-1:0] hcnt_q;
   logic [MEAS_W-1:0] hcnt_d;
   logic [MEAS_W-1:0] per_q;
   logic [MEAS_W-1:0] per_d;
   logic [MEAS_W-1:0] hi_q;
   logic [MEAS_W-1:0] hi_d;
   logic rise;

   // Computation state
   dsm_state_t st_q;
   dsm_state_t st_d;
   logic [31:0] num_q;
   logic [31:0] num_d;
   logic [MEAS_W-1:0] den_q;
   logic [MEAS_W-1:0] den_d;
   logic [15:0] quo_q;
   logic [15:0] quo_d;
   logic [3:0] bit_q;
   logic [3:0] bit_d;
   logic [7:0] duty_q;
   logic [7:0] duty_d;
   dsm_target_t tgt_q;
   dsm_target_t tgt_d;
   logic [47:0] trial;
   logic fits;
   logic [31:0] num_step;
   logic [15:0] quo_step;
   logic [RPM_W-1:0] min_rpm;
   logic [RPM_W-1:0] max_rpm;
   logic [RPM_W-1:0] span;

   // Output PWM state
   logic [OCW-1:0] ocnt_q;
   logic [OCW-1:0] ocnt_d;
   logic pwm_q;
   logic pwm_d;
   logic [31:0] pos_scaled;
   logic [31:0] thr_scaled;

   dsm_speed_rom u_rom (
      .clk(clk),
      .rst(rst),
      .min_code(prof_q.min_spd),
      .max_code(prof_q.max_spd),
      .min_rpm(min_rpm),
      .max_rpm(max_rpm)
   );

   // Register bus: one-cycle registered acknowledge
   always_comb begin
      idx = wb_adr_i[15:2];
      req = wb_cyc_i & wb_stb_i & ~ack_q;
      prof_d = prof_q;
      ack_d = req;
      dat_d = 32'h0;
      if (req & wb_we_i & wb_sel_i[0]) begin
         case (idx)
            IDX_MIN_SPD: prof_d.min_spd = wb_dat_i[7:0];
            IDX_MAX_SPD: prof_d.max_spd = wb_dat_i[7:0];
            IDX_DUTY_LO: prof_d.duty_lo = wb_dat_i[7:0];
            IDX_DUTY_HI: prof_d.duty_hi = wb_dat_i[7:0];
            IDX_OPTION: prof_d.full = wb_dat_i[FULL_BIT];
            default: prof_d = prof_q;
         endcase
      end
      if (req & ~wb_we_i) begin
         case (idx)
            IDX_MIN_SPD: dat_d = {24'h0, prof_q.min_spd};
            IDX_MAX_SPD: dat_d = {24'h0, prof_q.max_spd};
            IDX_DUTY_LO: dat_d = {24'h0, prof_q.duty_lo};
            IDX_DUTY_HI: dat_d = {24'h0, prof_q.duty_hi};
            IDX_OPTION: dat_d[FULL_BIT] = prof_q.full;
            IDX_DUTY_MEAS: dat_d = {24'h0, duty_q};
            IDX_TARGET: begin
               dat_d[RPM_W-1:0] = tgt_q.rpm;
               dat_d[BYPASS_BIT] = tgt_q.bypass;
            end
            default: dat_d = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prof_q <= '{RST_MIN_SPD, RST_MAX_SPD, RST_DUTY_LO, RST_DUTY_HI, RST_FULL};
         ack_q <= 1'b0;
         dat_q <= 32'h0;
      end else begin
         prof_q <= prof_d;
         ack_q <= ack_d;
         dat_q <= dat_d;
      end
   end

   assign wb_ack_o = ack_q;
   assign wb_dat_o = dat_q;

   // Input period and high time, measured from rising edge to rising edge
   always_comb begin
      sync_d = {sync_q[1:0], pwm_cmd_in};
      rise = sync_q[1] & ~sync_q[2];
      cnt_d = cnt_q;
      hcnt_d = hcnt_q;
      per_d = per_q;
      hi_d = hi_q;
      if (rise) begin
         // First edge after a steady level has no valid period behind it
         if (cnt_q < MEAS_W'(MEAS_TIMEOUT)) begin
            per_d = cnt_q;
            hi_d = hcnt_q;
         end
         cnt_d = MEAS_W'(1);
         // High time counts the delayed stage only, so it starts empty
         hcnt_d = '0;
      end else if (cnt_q >= MEAS_W'(MEAS_TIMEOUT)) begin
         // slower than 25 Hz is a steady level
         per_d = MEAS_W'(1);
         hi_d = {{(MEAS_W-1){1'b0}}, sync_q[2]};
      end else begin
         cnt_d = cnt_q + MEAS_W'(1);
         hcnt_d = hcnt_q + {{(MEAS_W-1){1'b0}}, sync_q[2]};
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync_q <= 3'h0;
         cnt_q <= '0;
         hcnt_q <= '0;
         per_q <= RST_PERIOD;
         hi_q <= '0;
      end else begin
         sync_q <= sync_d;
         cnt_q <= cnt_d;
         hcnt_q <= hcnt_d;
         per_q <= per_d;
         hi_q <= hi_d;
      end
   end

   // Shared serial divider: one quotient bit per cycle
   always_comb begin
      trial = {24'h0, den_q} << bit_q;
      fits = {16'h0, num_q} >= trial;
      num_step = fits ? num_q - trial[31:0] : num_q;
      quo_step = fits ? quo_q | (16'h1 << bit_q) : quo_q;
      span = (max_rpm >= min_rpm) ? max_rpm - min_rpm : '0;
   end

   always_comb begin
      st_d = st_q;
      num_d = num_q;
      den_d = den_q;
      quo_d = quo_q;
      bit_d = bit_q;
      duty_d = duty_q;
      tgt_d = tgt_q;
      case (st_q)
         ST_IDLE: begin
            // duty code = high * 255 / period
            num_d = 32'(hi_q) * 32'(DUTY_FULL);
            den_d = per_q;
            quo_d = 16'h0;
            bit_d = 4'h7;
            st_d = ST_DUTY;
         end
         ST_DUTY: begin
            num_d = num_step;
            quo_d = quo_step;
            bit_d = bit_q - 4'h1;
            if (bit_q == 4'h0) begin
               duty_d = quo_step[7:0];
               st_d = ST_SPLIT;
            end
         end
         ST_SPLIT: begin
            st_d = ST_IDLE;
            tgt_d.bypass = 1'b0;
            if (duty_q > prof_q.duty_hi) begin
               tgt_d.rpm = max_rpm;
               tgt_d.bypass = prof_q.full;
            end else if (duty_q <= prof_q.duty_lo) begin
               tgt_d.rpm = min_rpm;
            end else begin
               num_d = 32'(span) * 32'(duty_q - prof_q.duty_lo);
               den_d = MEAS_W'(prof_q.duty_hi - prof_q.duty_lo);
               quo_d = 16'h0;
               bit_d = 4'hF;
               st_d = ST_SPD;
            end
         end
         ST_SPD: begin
            num_d = num_step;
            quo_d = quo_step;
            bit_d = bit_q - 4'h1;
            if (bit_q == 4'h0) begin
               tgt_d.rpm = min_rpm + quo_step;
               tgt_d.bypass = 1'b0;
               st_d = ST_IDLE;
            end
         end
         default: st_d = ST_IDLE;
      endcase
   end

   // loop restarts every pass, so changes are picked up
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= ST_IDLE;
         num_q <= 32'h0;
         den_q <= '0;
         quo_q <= 16'h0;
         bit_q <= 4'h0;
         duty_q <= 8'h00;
         tgt_q <= '0;
      end else begin
         st_q <= st_d;
         num_q <= num_d;
         den_q <= den_d;
         quo_q <= quo_d;
         bit_q <= bit_d;
         duty_q <= duty_d;
         tgt_q <= tgt_d;
      end
   end

   assign target_rpm = tgt_q.rpm;
   assign regulation_bypass = tgt_q.bypass;

   // Output PWM: fixed period, independent of the input frequency
   always_comb begin
      pos_scaled = 32'(ocnt_q) << 8;
      thr_scaled = 32'(loop_duty) * 32'(OUT_PERIOD);
      if (ocnt_q == OCW'(OUT_PERIOD - 1)) ocnt_d = '0;
      else ocnt_d = ocnt_q + OCW'(1);
      pwm_d = tgt_q.bypass | (pos_scaled < thr_scaled);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ocnt_q <= '0;
         pwm_q <= 1'b0;
      end else begin
         ocnt_q <= ocnt_d;
         pwm_q <= pwm_d;
      end
   end

   assign pwm_out = pwm_q;
endmodule // dsm_duty_speed_map
`default_nettype wire

// [dsm_duty_speed_map_tb.sv]
// Self-checking bench for the duty to speed target map
`timescale 1ns/1ps
`default_nettype none
module dsm_duty_speed_map_tb
   import dsm_pkg::*;
;
   typedef struct packed {
      logic [7:0] mn, mx, lo, hd, du;
      logic fl, bp;
      logic [15:0] rpm;
   } dsm_row_t;
   // every row keeps max duty >= min duty and max speed >= min speed
   dsm_row_t rows [8] = '{
      '{8'h01, 8'hFF, 8'h00, 8'hFF, 8'h00, 1'b0, 1'b0, 16'h012C},
      '{8'h40, 8'h80, 8'h40, 8'hC0, 8'h80, 1'b0, 1'b0, 16'h1685},
      '{8'h40, 8'h80, 8'h40, 8'hC0, 8'hC0, 1'b0, 1'b0, 16'h2968},
      '{8'h40, 8'h80, 8'h40, 8'hC0, 8'hD0, 1'b0, 1'b0, 16'h2968},
      '{8'h40, 8'h80, 8'h40, 8'hC0, 8'hD0, 1'b1, 1'b1, 16'h0000},
      '{8'h00, 8'h00, 8'h00, 8'hFF, 8'h33, 1'b0, 1'b0, 16'h003C},
      '{8'hFF, 8'hFF, 8'h10, 8'h20, 8'h18, 1'b0, 1'b0, 16'h5AA0},
      '{8'h01, 8'hFF, 8'h00, 8'hFF, 8'hFF, 1'b0, 1'b0, 16'h8CA0}};
   logic clk = 1'b0, rst = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
   logic [15:0] adr = 16'h0000;
   logic [3:0] sel = 4'h0;
   logic [31:0] wdat = 32'h0, rdat, dat_o;
   logic ack, byp, pout, pin;
   logic [7:0] lduty = 8'h80;
   // Period of 2550 cycles is about 98 kHz; duty code = high / 10
   logic [15:0] per = 16'h09F6, hi = 16'h0000;
   logic [RPM_W-1:0] rpm;
   int failures = 0, checks = 0;
   always #2 clk = ~clk;
   dsm_host_pwm i_dsm_host_pwm (.clk(clk), .rst(rst), .period(per), .high(hi), .pwm_cmd(pin));
   dsm_duty_speed_map #(.MEAS_TIMEOUT(6000), .OUT_PERIOD(64)) i_dsm_duty_speed_map (.clk(clk),
      .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .pwm_cmd_in(pin), .loop_duty(lduty),
      .target_rpm(rpm), .regulation_bypass(byp), .pwm_out(pout));
   task automatic conclude();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   // One classic cycle, entered just after a rising edge
   task automatic bus(input logic w, input logic [15:0] a, input logic [31:0] d,
         input logic [3:0] s);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      sel <= s;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rdat = dat_o;
      if (ack !== 1'b1) begin
         failures++;
         $display("wrong value at %0t: got %0h expected %0h", $time, ack, 1'b1);
         conclude();
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      foreach (rows[i]) begin
         bus(1'b1, 16'h0400, {24'h0, rows[i].mn}, 4'h1);
         bus(1'b1, 16'h0404, {24'h0, rows[i].mx}, 4'h1);
         bus(1'b1, 16'h0408, {24'h0, rows[i].lo}, 4'h1);
         bus(1'b1, 16'h040C, {24'h0, rows[i].hd}, 4'h1);
         bus(1'b1, 16'h0424, {29'h0, rows[i].fl, 2'h0}, 4'h1);
         hi <= 16'(rows[i].du) * 16'h000A;
         // Steady full level needs one period plus the timeout before it reads 255
         repeat (9000) @(posedge clk);
         bus(1'b0, 16'h0440, 32'h0, 4'hF);
         cmp(rdat, {24'h0, rows[i].du});
         bus(1'b0, 16'h0424, 32'h0, 4'hF);
         cmp(rdat, {29'h0, rows[i].fl, 2'h0});
         cmp({31'h0, byp}, {31'h0, rows[i].bp});
         if (rows[i].bp) begin
            cmp({31'h0, pout}, 32'h1);
         end else begin
            cmp({16'h0, rpm}, {16'h0, rows[i].rpm});
            bus(1'b0, 16'h0444, 32'h0, 4'hF);
            cmp(rdat, {16'h0, rows[i].rpm});
         end
         $display("row %0d done", i);
      end
      bus(1'b1, 16'h0440, 32'h0, 4'h1);
      bus(1'b0, 16'h0440, 32'h0, 4'hF);
      cmp(rdat, 32'hFF);
      bus(1'b1, 16'h0404, 32'h0, 4'h2);
      bus(1'b0, 16'h0404, 32'h0, 4'hF);
      cmp(rdat, 32'hFF);
      bus(1'b1, 16'h0500, 32'hAB, 4'h1);
      bus(1'b0, 16'h0500, 32'h0, 4'hF);
      cmp(rdat, 32'h0);
      $display("read-only and unmapped done");
      lduty <= 8'h00;
      repeat (200) @(posedge clk);
      cmp({31'h0, pout}, 32'h0);
      $display("zero drive duty done");
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      cmp({16'h0, rpm}, 32'h0);
      rst <= 1'b0;
      @(posedge clk);
      bus(1'b0, 16'h0400, 32'h0, 4'hF);
      cmp(rdat, {24'h0, RST_MIN_SPD});
      bus(1'b0, 16'h0404, 32'h0, 4'hF);
      cmp(rdat, {24'h0, RST_MAX_SPD});
      bus(1'b0, 16'h0408, 32'h0, 4'hF);
      cmp(rdat, {24'h0, RST_DUTY_LO});
      bus(1'b0, 16'h040C, 32'h0, 4'hF);
      cmp(rdat, {24'h0, RST_DUTY_HI});
      $display("reset values done");
      conclude();
   end
endmodule // dsm_duty_speed_map_tb
`default_nettype wire

// [dsm_host_pwm.sv]
// Host model driving the speed command PWM pin
`timescale 1ns/1ps
`default_nettype none
module dsm_host_pwm (
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic [15:0] period, // PWM period in cycles
   input wire logic [15:0] high, // high time in cycles
   output logic pwm_cmd // command PWM pin
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   always_comb begin
      cnt_d = (cnt_q + 16'h0001 >= period) ? 16'h0000 : cnt_q + 16'h0001;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cnt_q <= 16'h0000;
         pwm_cmd <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         pwm_cmd <= (cnt_d < high);
      end
   end
endmodule // dsm_host_pwm
`default_nettype wire

// [dsm_map_props.sv]
// Port assertions for the duty to speed target map
`timescale 1ns/1ps
`default_nettype none
module dsm_map_props
   import dsm_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst, // reset
   input wire logic wb_cyc_i, // bus cycle
   input wire logic wb_stb_i, // bus strobe
   input wire logic wb_we_i, // bus write
   input wire logic [15:0] wb_adr_i, // bus address
   input wire logic [31:0] wb_dat_o, // read data
   input wire logic wb_ack_o, // acknowledge
   input wire logic [7:0] loop_duty, // regulator duty
   input wire logic [RPM_W-1:0] target_rpm, // target speed
   input wire logic regulation_bypass, // bypass flag
   input wire logic pwm_out // drive PWM
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   logic req;
   assign req = wb_cyc_i && wb_stb_i;
   AST_ACK_NEXT: assert property (req && !wb_ack_o |=> wb_ack_o)
      else $error("request not acknowledged next cycle");
   AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge longer than one cycle");
   AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i))
      else $error("acknowledge without request");
   AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside acknowledge");
   AST_OPT_BITS: assert property (req && !wb_we_i && wb_adr_i == 16'h0424 && !wb_ack_o
      |=> wb_dat_o[31:3] == 29'h0 && wb_dat_o[1:0] == 2'h0)
      else $error("option word has stray bits");
   AST_RPM_CEIL: assert property (target_rpm <= 16'h8CA0)
      else $error("target above top speed");
   AST_BYP_HIGH: assert property (regulation_bypass [*3] |-> pwm_out)
      else $error("drive not full during bypass");
   AST_PWM_ZERO: assert property ((loop_duty == 8'h00 && !regulation_bypass) [*3]
      |-> !pwm_out)
      else $error("drive high at zero duty");
   cover property (req && wb_we_i && wb_ack_o);
   cover property (req && !wb_we_i && wb_ack_o && wb_dat_o != 32'h0);
   cover property ($rose(regulation_bypass));
endmodule // dsm_map_props
bind dsm_duty_speed_map dsm_map_props i_dsm_map_props (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o), .loop_duty(loop_duty), .target_rpm(target_rpm),
   .regulation_bypass(regulation_bypass), .pwm_out(pwm_out));
`default_nettype wire

// [dsm_pkg.sv]
// Constants and types shared by the duty to speed target map
`default_nettype none
package dsm_pkg;
   // Clock and link timing
   localparam int CLK_HZ = 250_000_000;
   localparam int PWM_IN_MIN_HZ = 25;
   localparam int OUT_PWM_HZ = 48_000;
   // Longest legal input period; no edge for this long means a steady level
   localparam int MEAS_TIMEOUT_CYC = CLK_HZ / PWM_IN_MIN_HZ;
   localparam int OUT_PER_CYC = CLK_HZ / OUT_PWM_HZ;
   localparam int MEAS_W = 24;
   localparam int RPM_W = 16;
   localparam int CODE_W = 8;
   localparam logic [7:0] DUTY_FULL = 8'hFF;

   // Register indices; the byte address is four times the index
   localparam logic [13:0] IDX_MIN_SPD = 14'h0100;
   localparam logic [13:0] IDX_MAX_SPD = 14'h0101;
   localparam logic [13:0] IDX_DUTY_LO = 14'h0102;
   localparam logic [13:0] IDX_DUTY_HI = 14'h0103;
   localparam logic [13:0] IDX_OPTION = 14'h0109;
   localparam logic [13:0] IDX_DUTY_MEAS = 14'h0110;
   localparam logic [13:0] IDX_TARGET = 14'h0111;
   localparam int FULL_BIT = 2;
   localparam int BYPASS_BIT = 16;

   // Values after reset
   localparam logic [7:0] RST_MIN_SPD = 8'h00;
   localparam logic [7:0] RST_MAX_SPD = 8'hFF;
   localparam logic [7:0] RST_DUTY_LO = 8'h00;
   localparam logic [7:0] RST_DUTY_HI = 8'hFF;
   localparam logic RST_FULL = 1'b0;
   localparam logic [MEAS_W-1:0] RST_PERIOD = 24'h000001;

   // Max-speed table: piecewise linear segments (knee code, value at knee, step)
   localparam int MAXT_BASE = 300;
   localparam int MAXT_S1 = 20;
   localparam int MAXT_K1 = 41;
   localparam int MAXT_V1 = 1120;
   localparam int MAXT_S2 = 40;
   localparam int MAXT_K2 = 73;
   localparam int MAXT_V2 = 2400;
   localparam int MAXT_S3 = 100;
   localparam int MAXT_K3 = 101;
   localparam int MAXT_V3 = 5200;
   localparam int MAXT_S4 = 200;
   // Min-speed table: code 0 is standstill, then segments from code 1
   localparam int MINT_BASE = 300;
   localparam int MINT_S1 = 10;
   localparam int MINT_K1 = 83;
   localparam int MINT_V1 = 1120;
   localparam int MINT_S2 = 20;
   localparam int MINT_K2 = 147;
   localparam int MINT_V2 = 2400;
   localparam int MINT_S3 = 50;
   localparam int MINT_K3 = 203;
   localparam int MINT_V3 = 5200;
   localparam int MINT_S4 = 100;

   typedef struct packed {
      logic [CODE_W-1:0] min_spd;
      logic [CODE_W-1:0] max_spd;
      logic [CODE_W-1:0] duty_lo;
      logic [CODE_W-1:0] duty_hi;
      logic full;
   } dsm_prof_t;

   typedef struct packed {
      logic [RPM_W-1:0] rpm;
      logic bypass;
   } dsm_target_t;

   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_DUTY = 4'b0010,
      ST_SPLIT = 4'b0100,
      ST_SPD = 4'b1000
   } dsm_state_t;
endpackage
`default_nettype wire

// [dsm_speed_rom.sv]
// Speed code lookup with registered read data
`timescale 1ns/1ps
`default_nettype none
module dsm_speed_rom
   import dsm_pkg::*;
(
   input wire logic clk, // system clock
   input wire logic rst, // async reset, active high
   input wire logic [CODE_W-1:0] min_code, // minimum-speed code
   input wire logic [CODE_W-1:0] max_code, // maximum-speed code
   output logic [RPM_W-1:0] min_rpm, // decoded minimum speed
   output logic [RPM_W-1:0] max_rpm // decoded maximum speed
);
   logic [RPM_W-1:0] min_d;
   logic [RPM_W-1:0] max_d;
   logic [RPM_W-1:0] min_q;
   logic [RPM_W-1:0] max_q;

   function automatic logic [RPM_W-1:0] max_decode(input logic [CODE_W-1:0] c);
      int k;
      int v;
      k = int'(c);
      if (k <= MAXT_K1) v = MAXT_BASE + MAXT_S1 * k;
      else if (k <= MAXT_K2) v = MAXT_V1 + MAXT_S2 * (k - MAXT_K1);
      else if (k <= MAXT_K3) v = MAXT_V2 + MAXT_S3 * (k - MAXT_K2);
      else v = MAXT_V3 + MAXT_S4 * (k - MAXT_K3);
      return RPM_W'(v);
   endfunction

   function automatic logic [RPM_W-1:0] min_decode(input logic [CODE_W-1:0] c);
      int k;
      int v;
      k = int'(c);
      if (k == 0) v = 0;
      else if (k <= MINT_K1) v = MINT_BASE + MINT_S1 * (k - 1);
      else if (k <= MINT_K2) v = MINT_V1 + MINT_S2 * (k - MINT_K1);
      else if (k <= MINT_K3) v = MINT_V2 + MINT_S3 * (k - MINT_K2);
      else v = MINT_V3 + MINT_S4 * (k - MINT_K3);
      return RPM_W'(v);
   endfunction

   always_comb begin
      max_d = max_decode(max_code);
      min_d = min_decode(min_code);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         min_q <= '0;
         max_q <= '0;
      end else begin
         min_q <= min_d;
         max_q <= max_d;
      end
   end

   assign min_rpm = min_q;
   assign max_rpm = max_q;
endmodule // dsm_speed_rom
`default_nettype wire
